/* File: inc/psa_pkg.sv */
// Shared constants and types for the pipelined sample converter model.
// Assumes a single 50 MHz converter clock; sub-cycle analog delays are
// kept as named figures only, since they fall inside one clock period.
package psa_pkg;

  // ==========================================================================
  // Word format
  // ==========================================================================
  localparam int          PSA_WORD_W   = 8;
  localparam logic [7:0]  PSA_CODE_MIN = 8'h00;  // Straight binary bottom code.
  localparam logic [7:0]  PSA_CODE_MAX = 8'hFF;  // Straight binary top code.
  localparam logic [7:0]  PSA_OUT_RST  = 8'h00;
  localparam int          PSA_AIN_W    = 12;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int PSA_CLK_MHZ          = 50;
  localparam int PSA_APERTURE_DELAY_NS = 3;   // aperture_delay_time, sub-cycle.
  localparam int PSA_OUTPUT_DELAY_NS   = 14;  // output_delay_time, sub-cycle.
  localparam int PSA_LATENCY_HALVES    = 5;   // 2.5 clock cycles.
  localparam int PSA_PIPE_STAGES       = (PSA_LATENCY_HALVES - 1) / 2;
  localparam int PSA_WAKE_TIME_NS      = 140;
  localparam int PSA_WAKE_CYCLES       = (PSA_WAKE_TIME_NS * PSA_CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Power states
  // ==========================================================================
  typedef enum logic [1:0] {
    PSA_PWR_OFF,
    PSA_PWR_WAKE,
    PSA_PWR_ON
  } psa_pwr_t;

endpackage

/* File: rtl/psa_converter.sv */
// Top of the pipelined sample converter: falling-edge sampling, a rising
// edge pipeline, the parallel output word with its enable, and power-down.
// Assumes all inputs are synchronous to clk; the pad logic resolves the
// high-impedance level from data_oe.
//
// Overview of operation
// - Take each sample on the falling clock edge, hold after aperture delay.
// - Sample's word appears two and a half cycles later plus output delay.
// - A new word every clock cycle, trailing its conversion by fixed latency.
// - Output word changes only after a rising clock edge.
// - Convert while the clock runs; no clock means no new samples.
// - Power-down pin high powers down; low means normal operation.
// - While powered down, all output pins are high impedance; here only the data word floats (data_oe low), data_ready is driven low.
// - After power-down release, data is invalid for about 140 ns.
// - Inputs below bottom reference give the all-zero word.
// - Inputs above top reference give the all-one word.
// - Inputs between references resolve into eight-bit words.
`timescale 1ns/1ps
module psa_converter
  import psa_pkg::*;
#(
  parameter int AIN_W    = psa_pkg::PSA_AIN_W,
  parameter int STAGES   = psa_pkg::PSA_PIPE_STAGES,
  parameter int WAKE_CYC = psa_pkg::PSA_WAKE_CYCLES
)(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           clk_run,
  input  wire logic                           power_down_pin,
  input  wire logic [AIN_W-1:0]               ain,
  input  wire logic [AIN_W-1:0]               ref_bot,
  input  wire logic [AIN_W-1:0]               ref_top,
  output logic      [psa_pkg::PSA_WORD_W-1:0] data_out,
  output logic                                data_oe,
  output logic                                data_ready
);

  import psa_pkg::*;

  logic [PSA_WORD_W-1:0] quant_code;
  logic                  awake;
  logic [PSA_WORD_W-1:0] samp_reg;
  logic [PSA_WORD_W-1:0] samp_next;
  logic [PSA_WORD_W-1:0] pipe_reg  [STAGES];
  logic [PSA_WORD_W-1:0] pipe_next [STAGES];
  logic [PSA_WORD_W-1:0] out_reg;
  logic [PSA_WORD_W-1:0] out_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic                  rdy_reg;
  logic                  rdy_next;

  // ==========================================================================
  // Quantizer and power tracking
  // ==========================================================================
  // The quantizer is combinational; the falling-edge flop acts as the hold.
  psa_quantizer #(
    .AIN_W    (AIN_W)
  ) u_quant (
    .ain      (ain),
    .ref_bot  (ref_bot),
    .ref_top  (ref_top),
    .code     (quant_code)
  );

  psa_wake_timer #(
    .WAKE_CYC       (WAKE_CYC)
  ) u_wake (
    .clk            (clk),
    .rst            (rst),
    .power_down_pin (power_down_pin),
    .clk_run        (clk_run),
    .awake          (awake)
  );

  // ==========================================================================
  // Falling-edge sample
  // ==========================================================================
  // The aperture delay is a few nanoseconds, far inside the half period,
  // so the hold instant is modelled as the falling edge itself.
  always_comb
  begin
    samp_next = samp_reg;
    if (power_down_pin)
    begin
      samp_next = PSA_OUT_RST;
    end
    else if (clk_run)
    begin
      samp_next = quant_code;
    end
  end

  // Registers only, on the falling edge.
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
    begin
      samp_reg <= PSA_OUT_RST;
    end
    else
    begin
      samp_reg <= samp_next;
    end
  end

  // ==========================================================================
  // Rising-edge pipeline
  // ==========================================================================
  // Stage 0 takes the held sample half a cycle after it was taken; each
  // further stage adds one cycle, so the total comes to two and a half.
  for (genvar i = 0; i < STAGES; i++)
  begin : g_stage
    always_comb
    begin
      pipe_next[i] = pipe_reg[i];
      if (power_down_pin)
      begin
        pipe_next[i] = PSA_OUT_RST;
      end
      else if (clk_run)
      begin
        pipe_next[i] = (i == 0) ? samp_reg : pipe_reg[(i == 0) ? 0 : i - 1];
      end
    end

    // Registers only.
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        pipe_reg[i] <= PSA_OUT_RST;
      end
      else
      begin
        pipe_reg[i] <= pipe_next[i];
      end
    end
  end

  // ==========================================================================
  // Output stage
  // ==========================================================================
  // The ready flag marks words the capturing side may trust; it is low for
  // the settling interval, until the wake timer declares the converter awake.
  always_comb
  begin
    out_next = out_reg;
    oe_next  = 1'b1;
    rdy_next = 1'b0;
    if (power_down_pin)
    begin
      out_next = PSA_OUT_RST;
      oe_next  = 1'b0;
    end
    else if (clk_run)
    begin
      out_next = pipe_reg[STAGES-1];
    end
    if (!power_down_pin && awake)
    begin
      rdy_next = 1'b1;
    end
  end

  // Registers only; every top output leaves from here.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_reg <= PSA_OUT_RST;
      oe_reg  <= 1'b0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      rdy_reg <= rdy_next;
    end
  end

  assign data_out   = out_reg;
  assign data_oe    = oe_reg;
  assign data_ready = rdy_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Three running, powered cycles in a row.
  sequence seq_quiet_run;
    (clk_run && !power_down_pin) [*3];
  endsequence

  // Release cycle as the first of eight running, powered cycles.
  sequence seq_wake_run;
    $fell(power_down_pin) ##0 (clk_run && !power_down_pin) [*8];
  endsequence

  AST_LATENCY: assert property (
    @(posedge clk) disable iff (rst)
    seq_quiet_run |=> (data_out == $past(samp_reg, 3)))
    else $error("Output word does not trail its sample by the pipeline latency.");

  AST_SAT_LOW: assert property (
    @(posedge clk) disable iff (rst)
    (ain < ref_bot) |-> (quant_code == PSA_CODE_MIN))
    else $error("Input below bottom reference did not give the zero code.");

  AST_SAT_HIGH: assert property (
    @(posedge clk) disable iff (rst)
    ((ain > ref_top) && (ref_top > ref_bot)) |-> (quant_code == PSA_CODE_MAX))
    else $error("Input above top reference did not give the all-ones code.");

  AST_PD_HIZ: assert property (
    @(posedge clk) disable iff (rst)
    power_down_pin |=> (!data_oe && !data_ready && (data_out == PSA_OUT_RST)))
    else $error("Outputs still driven while powered down.");

  AST_OE_ON: assert property (
    @(posedge clk) disable iff (rst)
    !power_down_pin |=> data_oe)
    else $error("Outputs not driven in normal operation.");

  AST_WAKE: assert property (
    @(posedge clk) disable iff (rst)
    $fell(power_down_pin) |-> !data_ready [*8])
    else $error("Ready flag rose inside the settling interval.");

  AST_WAKE_END: assert property (
    @(posedge clk) disable iff (rst)
    seq_wake_run |=> data_ready)
    else $error("Ready flag late after the settling interval.");

  AST_HOLD: assert property (
    @(posedge clk) disable iff (rst)
    (!clk_run && !power_down_pin) |=> $stable(data_out))
    else $error("Output word changed while the converter clock was stopped.");

endmodule // psa_converter

/* File: rtl/psa_quantizer.sv */
// Combinational quantizer: maps an analog level between two references
// onto an eight-bit straight binary code with saturation at both ends.
// Assumes the level and references arrive as unsigned numbers on one scale.
`timescale 1ns/1ps
module psa_quantizer
  import psa_pkg::*;
#(
  parameter int AIN_W = psa_pkg::PSA_AIN_W
)(
  input  wire logic [AIN_W-1:0]            ain,
  input  wire logic [AIN_W-1:0]            ref_bot,
  input  wire logic [AIN_W-1:0]            ref_top,
  output logic      [psa_pkg::PSA_WORD_W-1:0] code
);

  logic [AIN_W-1:0]   span;
  logic [AIN_W+7:0]   num;
  logic [AIN_W+7:0]   quot;

  // ==========================================================================
  // Scaling
  // ==========================================================================
  // The quotient stays below 256 because the offset is smaller than the span.
  always_comb
  begin
    span = ref_top - ref_bot;
    num  = {ain - ref_bot, 8'h00};
    quot = (span == '0) ? '0 : num / {8'h00, span};
    if ((ain <= ref_bot) || (ref_top <= ref_bot))
    begin
      code = PSA_CODE_MIN;
    end
    else if (ain >= ref_top)
    begin
      code = PSA_CODE_MAX;
    end
    else
    begin
      code = quot[7:0];
    end
  end

endmodule // psa_quantizer

/* File: rtl/psa_wake_timer.sv */
// Power state tracker: holds the converter off while power-down is high
// and counts the settling time after release before declaring it awake.
// Assumes power_down_pin is synchronous to clk.
`timescale 1ns/1ps
module psa_wake_timer
  import psa_pkg::*;
#(
  parameter int WAKE_CYC = psa_pkg::PSA_WAKE_CYCLES
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic power_down_pin,
  input  wire logic clk_run,
  output logic      awake
);

  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(WAKE_CYC);

  psa_pwr_t       state_reg;
  psa_pwr_t       state_next;
  logic [CW-1:0]  cnt_reg;
  logic [CW-1:0]  cnt_next;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // In WAKE the count only advances on running cycles; the release cycle loads CNT_LOAD - 1 whatever clk_run is.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      PSA_PWR_OFF:
      begin
        cnt_next = CNT_LOAD;
        if (!power_down_pin)
        begin
          state_next = PSA_PWR_WAKE;
          cnt_next   = CNT_LOAD - CW'(1);
        end
      end
      PSA_PWR_WAKE:
      begin
        if (clk_run && (cnt_reg != '0))
        begin
          cnt_next = cnt_reg - CW'(1);
        end
        // A count that starts at zero (one-cycle settling) still ends the wait.
        if (clk_run && (cnt_reg <= CW'(1)))
        begin
          state_next = PSA_PWR_ON;
        end
      end
      PSA_PWR_ON:
      begin
        cnt_next = '0;
      end
    endcase
    if (power_down_pin)
    begin
      state_next = PSA_PWR_OFF;
      cnt_next   = CNT_LOAD;
    end
  end

  // Registers only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= PSA_PWR_OFF;
      cnt_reg   <= CNT_LOAD;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign awake = (state_reg == PSA_PWR_ON);

endmodule // psa_wake_timer

/* File: verification/pipelined_adc_sample_output_tb_top.sv */
// Self-checking bench for psa_converter with the capture model attached.
// Assumes a 50 MHz clk and inputs that change only at rising edges.
`timescale 1ns/1ps
module pipelined_adc_sample_output_tb_top;
  import psa_pkg::*;

  logic                  clk            = 1'b0;
  logic                  rst            = 1'b1;
  logic                  clk_run        = 1'b1;
  logic                  power_down_pin = 1'b0;
  logic [PSA_AIN_W-1:0]  ain            = 12'h000;
  logic [PSA_AIN_W-1:0]  ref_bot        = 12'h100;
  logic [PSA_AIN_W-1:0]  ref_top        = 12'h900;
  logic [PSA_WORD_W-1:0] data_out;
  logic                  data_oe;
  logic                  data_ready;
  logic [PSA_WORD_W-1:0] pin_level;
  logic [PSA_WORD_W-1:0] cap_word;
  logic                  cap_valid;
  int                    bad_count = 0;
  int                    n_checks  = 0;
  int                    cycles    = 0;

  psa_converter uut (
    .clk            (clk),
    .rst            (rst),
    .clk_run        (clk_run),
    .power_down_pin (power_down_pin),
    .ain            (ain),
    .ref_bot        (ref_bot),
    .ref_top        (ref_top),
    .data_out       (data_out),
    .data_oe        (data_oe),
    .data_ready     (data_ready)
  );

  psa_capture_model far_end (
    .clk        (clk),
    .data_out   (data_out),
    .data_oe    (data_oe),
    .data_ready (data_ready),
    .pin_level  (pin_level),
    .cap_word   (cap_word),
    .cap_valid  (cap_valid)
  );

  // ==========================================================================
  // Clock, timeout and helpers
  // ==========================================================================
  // Free-running clock at a 20 ns period.
  initial
  begin
    forever #10 clk = ~clk;
  end

  // The tests need well under a thousand cycles; a hang is cut at 5000.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expect_v, input string msg);
    n_checks++;
    if (seen !== expect_v)
    begin
      bad_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, expect_v);
    end
  endtask

  // Reference quantizer from the straight binary transfer rule.
  function automatic logic [7:0] quant(input logic [11:0] a);
    if (a <= ref_bot)
      return 8'h00;
    if (a >= ref_top)
      return 8'hFF;
    return 8'((int'(a - ref_bot) * 256) / int'(ref_top - ref_bot));
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Back-to-back samples through the pipeline, one word per cycle.
  task automatic run_stream();
    logic [11:0] v [11] = '{12'h000, 12'h100, 12'h108, 12'h500, 12'h8FF, 12'h900,
                            12'hFFF, 12'h1FF, 12'h500, 12'h500, 12'h500};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      ain <= v[i];
      #1;
      if (i >= 3) check(data_out, quant(v[i-3]), "stream word");
    end
  endtask

  // A stopped clock freezes the pipeline; resuming delivers the new level.
  task automatic run_freeze();
    @(posedge clk);
    clk_run <= 1'b0;
    ain     <= 12'h900;
    for (int k = 0; k < 4; k++)
    begin
      tick();
      check(data_out, 8'h80, "frozen word");
    end
    @(posedge clk);
    clk_run <= 1'b1;
    repeat (4) tick();
    check(data_out, 8'hFF, "resumed word");
  endtask

  // Power-down floats the pins, release waits out the settling time.
  // The last driven word is 80h, so a floating bus must read 7Fh, not a driven zero.
  task automatic run_power_down();
    @(posedge clk);
    ain <= 12'h500;
    repeat (3) tick();
    @(posedge clk);
    power_down_pin <= 1'b1;
    tick();
    check({6'h00, data_oe, data_ready}, 8'h00, "powered down");
    check(pin_level, 8'h7F, "floating pins");
    repeat (3) tick();
    @(posedge clk);
    power_down_pin <= 1'b0;
    ain            <= 12'h900;
    for (int k = 0; k < 8; k++)
    begin
      tick();
      check({7'h00, data_oe}, 8'h01, "driven after release");
      check({7'h00, data_ready}, {7'h00, k == 7}, "settling flag");
      check({7'h00, cap_valid}, 8'h00, "settling word ignored");
    end
    tick();
    check(cap_word, 8'hFF, "captured word");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (7) tick();
    check({7'h00, data_ready}, 8'h00, "settling after reset");
    tick();
    check({7'h00, data_ready}, 8'h01, "ready after reset");
    run_stream();
    run_freeze();
    run_power_down();
    complete_run();
  end
endmodule // pipelined_adc_sample_output_tb_top

/* File: verification/psa_capture_model.sv */
// Capture logic model that sits on the far side of the converter word.
// Assumes data_out, data_oe and data_ready come from psa_converter on clk.
`timescale 1ns/1ps
module psa_capture_model
  import psa_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic [psa_pkg::PSA_WORD_W-1:0] data_out,
  input  wire logic                           data_oe,
  input  wire logic                           data_ready,
  output logic      [psa_pkg::PSA_WORD_W-1:0] pin_level,
  output logic      [psa_pkg::PSA_WORD_W-1:0] cap_word,
  output logic                                cap_valid
);
  import psa_pkg::*;

  // ==========================================================================
  // Pin level
  // ==========================================================================
  // released pins float
  // With no pull on the pins, an undriven bus shows the inverse of the last driven word.
  logic [PSA_WORD_W-1:0] last_reg;
  assign pin_level = data_oe ? data_out : ~last_reg;

  // ==========================================================================
  // Capture
  // ==========================================================================
  // rising-edge capture, settling ignored
  // Falling-edge capture would race the output delay, so only rising edges latch.
  always_ff @(posedge clk)
  begin
    // Only a driven word is remembered, so a floating bus stays put.
    if (data_oe)
    begin
      last_reg <= data_out;
    end
    cap_valid <= data_oe & data_ready;
    if (data_oe & data_ready)
    begin
      cap_word <= pin_level;
    end
  end
endmodule // psa_capture_model
